// ---- src/aopc_regs.svh ----
`ifndef AOPC_REGS_SVH
`define AOPC_REGS_SVH

// sample word layout
`define AOPC_SAMPLE_W 14
`define AOPC_MSB_POS 13
`define AOPC_LSB_POS 0
// samples of delay between capture and output
`define AOPC_LATENCY 7
// format select codes (four-level input digitised to two bits)
`define AOPC_FMT_OB_NOSTAB 2'h0
`define AOPC_FMT_OB_STAB 2'h1
`define AOPC_FMT_TC_STAB 2'h2
`define AOPC_FMT_TC_NOSTAB 2'h3
// interrupt status bits
`define AOPC_IRQ_RANGE_BIT 0
`define AOPC_IRQ_SAMPLE_BIT 1
`define AOPC_IRQ_W 2
// register byte offsets
`define AOPC_REG_CTRL 4'h0
`define AOPC_REG_STATUS 4'h4
`define AOPC_REG_IRQ_STAT 4'h8
`define AOPC_REG_IRQ_MASK 4'hc
// control field positions
`define AOPC_CTRL_RANGE_POS 0
`define AOPC_CTRL_STAB_POS 1
// control reset value
`define AOPC_CTRL_RESET 32'h00000000

`endif

// ---- src/aopc_pkg.sv ----
package aopc_pkg;
    typedef logic [13:0] aopc_word_type;
    typedef enum logic [1:0] {
        AOPC_IDLE = 2'b00,
        AOPC_RUN = 2'b01,
        AOPC_OFF = 2'b10
    } aopc_state_type;
    typedef struct packed {
        logic twosComp;
        logic stabOn;
    } aopc_fmt_type;
endpackage

// ---- src/aopc_sample_if.sv ----
`timescale 1ns/100ps
`default_nettype none
interface aopc_sample_if;
    import aopc_pkg::*;
    logic strobe;
    aopc_word_type word;
    logic over;
    aopc_fmt_type fmt;
    logic randOn;
    modport src (output strobe, output word, output over);
    modport snk (input strobe, input word, input over, input fmt, input randOn);
    modport cfg (output fmt, output randOn);
endinterface
`default_nettype wire

// ---- src/aopc_pipe.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "aopc_regs.svh"
module aopc_pipe import aopc_pkg::*; (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // capture strobe and raw sample
    input wire logic capture,
    input wire aopc_word_type rawWord,
    input wire logic rawOver,
    // delayed sample out
    aopc_sample_if.src outp
);
    aopc_word_type wordPipe_q [`AOPC_LATENCY];
    logic overPipe_q [`AOPC_LATENCY];
    aopc_word_type wordOut_q;
    logic overOut_q;
    logic strobe_q;

    // one stage per encode cycle of delay
    genvar i;
    generate
        for (i = 0; i < `AOPC_LATENCY; i++) begin : g_stage
            if (i == 0) begin : g_first
                always_ff @(posedge clk) begin
                    if (sys_rst) begin
                        wordPipe_q[i] <= 14'h0000;
                        overPipe_q[i] <= 1'b0;
                    end else if (capture) begin
                        wordPipe_q[i] <= rawWord;
                        overPipe_q[i] <= rawOver;
                    end
                end
            end else begin : g_next
                always_ff @(posedge clk) begin
                    if (sys_rst) begin
                        wordPipe_q[i] <= 14'h0000;
                        overPipe_q[i] <= 1'b0;
                    end else if (capture) begin
                        wordPipe_q[i] <= wordPipe_q[i-1];
                        overPipe_q[i] <= overPipe_q[i-1];
                    end
                end
            end
        end
    endgenerate

    // last stage leaves on the seventh following capture
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wordOut_q <= 14'h0000;
            overOut_q <= 1'b0;
        end else if (capture) begin
            wordOut_q <= wordPipe_q[`AOPC_LATENCY-1];
            overOut_q <= overPipe_q[`AOPC_LATENCY-1];
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            strobe_q <= 1'b0;
        end else begin
            strobe_q <= capture;
        end
    end

    assign outp.strobe = strobe_q;
    assign outp.word = wordOut_q;
    assign outp.over = overOut_q;
endmodule
`default_nettype wire

// ---- src/aopc_format.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "aopc_regs.svh"
module aopc_format import aopc_pkg::*; (
    // format select level
    input wire logic [1:0] formatSel,
    input wire logic randIn,
    // decoded configuration
    aopc_sample_if.cfg cfg
);
    aopc_fmt_type fmt;

    always_comb begin
        fmt = '0;
        case (formatSel)
            `AOPC_FMT_OB_NOSTAB: begin
                fmt.twosComp = 1'b0;
                fmt.stabOn = 1'b0;
            end
            `AOPC_FMT_OB_STAB: begin
                fmt.twosComp = 1'b0;
                fmt.stabOn = 1'b1;
            end
            `AOPC_FMT_TC_STAB: begin
                fmt.twosComp = 1'b1;
                fmt.stabOn = 1'b1;
            end
            default: begin
                fmt.twosComp = 1'b1;
                fmt.stabOn = 1'b0;
            end
        endcase
    end

    assign cfg.fmt = fmt;
    assign cfg.randOn = randIn;
endmodule
`default_nettype wire

// ---- src/aopc_port.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "aopc_regs.svh"
// Summary of operation
// - fourteen output lines, top line is the most significant bit
// - sample is taken when positive encode input rises
// - data-valid pair toggles each sample; receiver latches on its edge
// - range flag high when the sample left the conversion range
// - low output enable drives outputs, high makes them float
// - power-down high stops conversion and floats all outputs
// - dither enable input switches internal dither on or off
// - four-level format input picks number format and stabilizer
// - randomizer XORs bit zero into all upper bits
// - gain select low gives gain one, high gives gain 1.5
// - each result appears seven encode cycles after its sample
module aopc_port import aopc_pkg::*; (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // encode clock pair
    input wire logic encode_clk_pos,
    input wire logic encode_clk_neg,
    // converter core sample
    input wire aopc_word_type coreWord,
    input wire logic coreOver,
    // static controls
    input wire logic power_down_in,
    input wire logic outputEnable_n,
    input wire logic dither_enable,
    input wire logic randomizer_enable,
    input wire logic gain_select,
    input wire logic [1:0] formatSel,
    // analog steering
    output logic ditherOn,
    output logic gainHigh,
    output logic analogPowerDown,
    output logic stabilizerOn,
    // sample word pins
    output logic [13:0] sample_bits,
    output logic [13:0] sampleBitsOe,
    output logic range_violation_flag,
    output logic rangeFlagOe,
    output logic data_valid_clk_pos,
    output logic data_valid_clk_neg,
    output logic dataValidOe,
    // avalon-mm slave
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // interrupt
    output logic irq
);
    aopc_sample_if smp();

    logic encPos1_q, encPos2_q, encNeg1_q, encNeg2_q, encLast_q;
    logic pd1_q, pd2_q, oe1_q, oe2_q, di1_q, di2_q, rn1_q, rn2_q, gs1_q, gs2_q;
    logic [1:0] fs1_q, fs2_q;
    aopc_word_type cw1_q, cw2_q;
    logic co1_q, co2_q;
    logic encHigh, encRise, capture, outDrive;
    aopc_state_type state_q;
    aopc_word_type outWord;
    logic [31:0] ctrl_q;
    logic [`AOPC_IRQ_W-1:0] irqStat_q, irqMask_q, irqEvt;
    logic ack_q;
    logic [3:0] heldOff_q;

    // two-flop synchronisers for pins
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            encPos1_q <= 1'b0;
            encPos2_q <= 1'b0;
            encNeg1_q <= 1'b0;
            encNeg2_q <= 1'b0;
            pd1_q <= 1'b1;
            pd2_q <= 1'b1;
            oe1_q <= 1'b1;
            oe2_q <= 1'b1;
            di1_q <= 1'b0;
            di2_q <= 1'b0;
            rn1_q <= 1'b0;
            rn2_q <= 1'b0;
            gs1_q <= 1'b0;
            gs2_q <= 1'b0;
            fs1_q <= 2'h0;
            fs2_q <= 2'h0;
            cw1_q <= 14'h0000;
            cw2_q <= 14'h0000;
            co1_q <= 1'b0;
            co2_q <= 1'b0;
        end else begin
            encPos1_q <= encode_clk_pos;
            encPos2_q <= encPos1_q;
            encNeg1_q <= encode_clk_neg;
            encNeg2_q <= encNeg1_q;
            pd1_q <= power_down_in;
            pd2_q <= pd1_q;
            oe1_q <= outputEnable_n;
            oe2_q <= oe1_q;
            di1_q <= dither_enable;
            di2_q <= di1_q;
            rn1_q <= randomizer_enable;
            rn2_q <= rn1_q;
            gs1_q <= gain_select;
            gs2_q <= gs1_q;
            fs1_q <= formatSel;
            fs2_q <= fs1_q;
            cw1_q <= coreWord;
            cw2_q <= cw1_q;
            co1_q <= coreOver;
            co2_q <= co1_q;
        end
    end

    // differential encode: high when positive above negative
    assign encHigh = encPos2_q & ~encNeg2_q;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            encLast_q <= 1'b0;
        end else begin
            encLast_q <= encHigh;
        end
    end

    assign encRise = encHigh & ~encLast_q;
    assign capture = encRise & (state_q == AOPC_RUN);

    // run state follows power-down
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_q <= AOPC_IDLE;
        end else begin
            case (state_q)
                AOPC_IDLE: begin
                    state_q <= pd2_q ? AOPC_OFF : AOPC_RUN;
                end
                AOPC_RUN: begin
                    if (pd2_q) begin
                        state_q <= AOPC_OFF;
                    end
                end
                AOPC_OFF: begin
                    if (!pd2_q) begin
                        state_q <= AOPC_RUN;
                    end
                end
                default: begin
                    state_q <= AOPC_IDLE;
                end
            endcase
        end
    end

    aopc_pipe u_pipe (
        .clk(clk),
        .sys_rst(sys_rst),
        .capture(capture),
        .rawWord(cw2_q),
        .rawOver(co2_q),
        .outp(smp.src)
    );

    aopc_format u_format (
        .formatSel(fs2_q),
        .randIn(rn2_q),
        .cfg(smp.cfg)
    );

    // format and randomize the delayed word
    always_comb begin
        outWord = smp.word;
        if (smp.fmt.twosComp) begin
            outWord[`AOPC_MSB_POS] = ~smp.word[`AOPC_MSB_POS];
        end
        if (smp.randOn) begin
            outWord[`AOPC_MSB_POS:1] = outWord[`AOPC_MSB_POS:1]
                ^ {(`AOPC_SAMPLE_W-1){outWord[`AOPC_LSB_POS]}};
        end
    end

    assign outDrive = ~oe2_q & ~pd2_q & (state_q == AOPC_RUN);

    // output pins and enables
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sample_bits <= 14'h0000;
            range_violation_flag <= 1'b0;
            data_valid_clk_pos <= 1'b0;
            data_valid_clk_neg <= 1'b1;
        end else if (smp.strobe) begin
            sample_bits <= outWord;
            range_violation_flag <= smp.over;
            data_valid_clk_pos <= ~data_valid_clk_pos;
            data_valid_clk_neg <= data_valid_clk_pos;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sampleBitsOe <= 14'h0000;
            rangeFlagOe <= 1'b0;
            dataValidOe <= 1'b0;
        end else begin
            sampleBitsOe <= {`AOPC_SAMPLE_W{outDrive}};
            rangeFlagOe <= outDrive;
            dataValidOe <= outDrive;
        end
    end

    // analog steering
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ditherOn <= 1'b0;
            gainHigh <= 1'b0;
            analogPowerDown <= 1'b1;
            stabilizerOn <= 1'b0;
        end else begin
            ditherOn <= di2_q;
            gainHigh <= gs2_q;
            analogPowerDown <= pd2_q;
            stabilizerOn <= smp.fmt.stabOn;
        end
    end

    // interrupt events
    assign irqEvt[`AOPC_IRQ_RANGE_BIT] = smp.strobe & smp.over;
    assign irqEvt[`AOPC_IRQ_SAMPLE_BIT] = smp.strobe;

    // bus: one wait cycle, then ack
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= (avs_read | avs_write) & ~ack_q;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            avs_waitrequest <= 1'b1;
        end else begin
            avs_waitrequest <= ~((avs_read | avs_write) & ~ack_q & avs_waitrequest);
        end
    end

    logic doWrite;
    assign doWrite = avs_write & ~avs_waitrequest;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ctrl_q <= `AOPC_CTRL_RESET;
            irqMask_q <= '0;
        end else if (doWrite) begin
            if (avs_address == `AOPC_REG_CTRL && avs_byteenable[0]) begin
                ctrl_q[7:0] <= avs_writedata[7:0];
            end
            if (avs_address == `AOPC_REG_IRQ_MASK && avs_byteenable[0]) begin
                irqMask_q <= avs_writedata[`AOPC_IRQ_W-1:0];
            end
        end
    end

    // sticky status, set wins over clear
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            irqStat_q <= '0;
        end else if (doWrite && avs_address == `AOPC_REG_IRQ_STAT && avs_byteenable[0]) begin
            irqStat_q <= (irqStat_q & ~avs_writedata[`AOPC_IRQ_W-1:0]) | irqEvt;
        end else begin
            irqStat_q <= irqStat_q | irqEvt;
        end
    end

    // sample counter of output words held while drive is off
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            heldOff_q <= 4'h0;
        end else if (smp.strobe && !outDrive && heldOff_q != 4'hf) begin
            heldOff_q <= heldOff_q + 4'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            avs_readdata <= 32'h00000000;
        end else if (avs_read && ack_q == 1'b0 && avs_waitrequest) begin
            case (avs_address)
                `AOPC_REG_CTRL: avs_readdata <= {24'h000000, ctrl_q[7:0]};
                `AOPC_REG_STATUS: avs_readdata <= {5'h00, heldOff_q, state_q, outDrive,
                    smp.fmt.twosComp, smp.fmt.stabOn, rn2_q, gs2_q, di2_q, smp.over, smp.word};
                `AOPC_REG_IRQ_STAT: avs_readdata <= {30'h00000000, irqStat_q};
                `AOPC_REG_IRQ_MASK: avs_readdata <= {30'h00000000, irqMask_q};
                default: avs_readdata <= 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irqStat_q & irqMask_q);
        end
    end

    logic unusedCtrl;
    assign unusedCtrl = ^ctrl_q;
endmodule
`default_nettype wire

// ---- test/aopc_port_monitor.sv ----
`timescale 1ns/100ps
`default_nettype none
module aopc_port_monitor (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // static controls
    input wire logic power_down_in,
    input wire logic outputEnable_n,
    input wire logic dither_enable,
    input wire logic gain_select,
    input wire logic [1:0] formatSel,
    // observed outputs
    input wire logic ditherOn,
    input wire logic gainHigh,
    input wire logic analogPowerDown,
    input wire logic stabilizerOn,
    input wire logic [13:0] sample_bits,
    input wire logic [13:0] sampleBitsOe,
    input wire logic rangeFlagOe,
    input wire logic data_valid_clk_pos,
    input wire logic data_valid_clk_neg,
    input wire logic dataValidOe
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    sequence seqFloatReq;
        (power_down_in || outputEnable_n) [*5];
    endsequence
    sequence seqDriveReq;
        (!power_down_in && !outputEnable_n) [*8];
    endsequence
    a_dv_complement: assert property (data_valid_clk_pos != data_valid_clk_neg)
        else $error("data valid pair not complementary");
    a_dv_spacing: assert property ($changed(data_valid_clk_pos) |=> $stable(data_valid_clk_pos) [*6])
        else $error("data valid toggles too often");
    a_data_with_dv: assert property ($changed(sample_bits) |-> $changed(data_valid_clk_pos))
        else $error("data changed without data valid toggle");
    a_float_outputs: assert property (seqFloatReq |-> sampleBitsOe == 14'h0 && !rangeFlagOe && !dataValidOe)
        else $error("outputs driven while disabled");
    a_drive_outputs: assert property (seqDriveReq |-> sampleBitsOe == 14'h3fff && rangeFlagOe && dataValidOe)
        else $error("outputs not driven while enabled");
    a_power_analog: assert property ($stable(power_down_in) [*5] |-> analogPowerDown == power_down_in)
        else $error("analog power state wrong");
    a_dither_follow: assert property ($stable(dither_enable) [*5] |-> ditherOn == dither_enable)
        else $error("dither state wrong");
    a_gain_follow: assert property ($stable(gain_select) [*5] |-> gainHigh == gain_select)
        else $error("gain state wrong");
    a_stab_decode: assert property ($stable(formatSel) [*5] |-> stabilizerOn == (formatSel == 2'h1 || formatSel == 2'h2))
        else $error("stabilizer decode wrong");
endmodule
`default_nettype wire

// ---- test/aopc_capture_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module aopc_capture_model (
    // clock
    input wire logic clk,
    // observed pins
    input wire logic [13:0] sample_bits,
    input wire logic [13:0] sampleBitsOe,
    input wire logic range_violation_flag,
    input wire logic rangeFlagOe,
    input wire logic data_valid_clk_pos,
    input wire logic dataValidOe,
    input wire logic randOn,
    // restored sample
    output logic [13:0] word,
    output logic over,
    output logic got
);
    logic [13:0] pinLast_q;
    logic [13:0] pinWord;
    logic dvLast_q;
    logic dvRise;
    // released lines read back inverted
    assign pinWord = (sample_bits & sampleBitsOe) | (~pinLast_q & ~sampleBitsOe);
    assign dvRise = data_valid_clk_pos && dataValidOe && !dvLast_q;
    always @(posedge clk) begin
        pinLast_q <= pinWord;
        dvLast_q <= data_valid_clk_pos && dataValidOe;
        got <= dvRise;
        if (dvRise) begin
            word <= randOn ? pinWord ^ {{13{pinWord[0]}}, 1'b0} : pinWord;
            over <= range_violation_flag && rangeFlagOe;
        end
    end
endmodule
`default_nettype wire

// ---- test/test_adc_output_port_control.sv ----
`timescale 1ns/100ps
`default_nettype none
module test_adc_output_port_control import aopc_pkg::*;;
    typedef struct packed {
        logic [1:0] fmt;
        logic rnd, dit, gain, pd, oen, stab, drv;
    } aopc_row_type;
    logic clk, sys_rst, encode_clk_pos, encode_clk_neg, coreOver, power_down_in, outputEnable_n;
    logic dither_enable, randomizer_enable, gain_select, ditherOn, gainHigh, analogPowerDown, stabilizerOn;
    logic range_violation_flag, rangeFlagOe, data_valid_clk_pos, data_valid_clk_neg, dataValidOe;
    logic avs_read, avs_write, avs_waitrequest, irq, capOver, capGot;
    logic [1:0] formatSel;
    logic [2:0] encPhase;
    logic [3:0] avs_address, avs_byteenable;
    logic [13:0] sample_bits, sampleBitsOe, capWord, expW, latW;
    logic [31:0] avs_writedata, avs_readdata, rd;
    aopc_word_type coreWord;
    logic encRun;
    int riseCnt, rowStart, n_fail, cmp_count;
    aopc_row_type rows [7] = '{'{2'h0, 0, 0, 0, 0, 0, 0, 1}, '{2'h1, 1, 1, 0, 0, 0, 1, 1},
        '{2'h2, 0, 0, 1, 0, 0, 1, 1}, '{2'h3, 1, 1, 1, 0, 0, 0, 1}, '{2'h1, 0, 1, 0, 0, 1, 1, 0},
        '{2'h2, 1, 0, 1, 1, 0, 1, 0}, '{2'h0, 1, 0, 0, 0, 0, 0, 1}};
    aopc_port dut (.clk, .sys_rst, .encode_clk_pos, .encode_clk_neg, .coreWord, .coreOver, .power_down_in,
        .outputEnable_n, .dither_enable, .randomizer_enable, .gain_select, .formatSel, .ditherOn, .gainHigh,
        .analogPowerDown, .stabilizerOn, .sample_bits, .sampleBitsOe, .range_violation_flag, .rangeFlagOe,
        .data_valid_clk_pos, .data_valid_clk_neg, .dataValidOe, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .irq);
    aopc_capture_model cap (.clk, .sample_bits, .sampleBitsOe, .range_violation_flag, .rangeFlagOe,
        .data_valid_clk_pos, .dataValidOe, .randOn(randomizer_enable), .word(capWord), .over(capOver),
        .got(capGot));
    function automatic logic [13:0] sampleOf(input int r);
        return 14'h0a53 + 14'(r) * 14'h0137;
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic summarize;
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        @(posedge clk);
        while (avs_waitrequest !== 1'b0) begin
            @(posedge clk);
            n++;
        end
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clk);
    endtask
    task automatic doReset;
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        chk({data_valid_clk_pos, data_valid_clk_neg, avs_waitrequest, irq, sampleBitsOe}, {4'b0110, 14'h0});
    endtask
    // encode clock, eight system clocks per sample, word set at start of low phase
    assign encode_clk_pos = encPhase[2];
    assign encode_clk_neg = ~encPhase[2];
    always @(posedge clk) begin
        if (encRun) begin
            encPhase <= encPhase + 3'h1;
            if (encPhase == 3'h3) riseCnt <= riseCnt + 1;
            if (encPhase == 3'h7) begin
                coreWord <= sampleOf(riseCnt);
                coreOver <= riseCnt[0];
            end
        end
        if (capGot === 1'b1 && riseCnt >= rowStart + 9) begin
            expW = sampleOf(riseCnt - 8);
            expW[13] = expW[13] ^ formatSel[1];
            chk({capOver, capWord}, {riseCnt[0], expW});
        end
        if (encRun && encPhase == 3'h3 && sampleBitsOe[0] === 1'b1 && riseCnt >= rowStart + 9) begin
            latW = randomizer_enable ? sample_bits ^ {{13{sample_bits[0]}}, 1'b0} : sample_bits;
            expW = sampleOf(riseCnt - 8);
            expW[13] = expW[13] ^ formatSel[1];
            chk(latW, expW);
        end
    end
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial begin
        #40000;
        n_fail++;
        summarize();
    end
    initial begin
        sys_rst = 1'b1;
        {encRun, encPhase, riseCnt, rowStart, coreWord, coreOver} = '0;
        {power_down_in, outputEnable_n, dither_enable, randomizer_enable, gain_select, formatSel} = '0;
        {avs_address, avs_read, avs_write, avs_writedata} = '0;
        avs_byteenable = 4'hf;
        doReset();
        encRun <= 1'b1;
        for (int i = 0; i < 7; i++) begin
            formatSel <= rows[i].fmt;
            randomizer_enable <= rows[i].rnd;
            dither_enable <= rows[i].dit;
            gain_select <= rows[i].gain;
            power_down_in <= rows[i].pd;
            outputEnable_n <= rows[i].oen;
            rowStart <= riseCnt;
            repeat (120) @(posedge clk);
            chk({ditherOn, gainHigh, stabilizerOn, analogPowerDown, dataValidOe, rangeFlagOe, sampleBitsOe},
                {rows[i].dit, rows[i].gain, rows[i].stab, rows[i].pd, {16{rows[i].drv}}});
        end
        bus(1'b1, 4'h0, 32'hffff_ffa5, rd);
        bus(1'b0, 4'h0, 32'h0, rd);
        chk(rd, 32'h0000_00a5);
        bus(1'b1, 4'h2, 32'hffff_ffff, rd);
        bus(1'b0, 4'h2, 32'h0, rd);
        chk(rd, 32'h0);
        bus(1'b1, 4'hc, 32'h2, rd);
        repeat (20) @(posedge clk);
        chk(irq, 1);
        bus(1'b1, 4'hc, 32'h0, rd);
        repeat (3) @(posedge clk);
        chk(irq, 0);
        encRun <= 1'b0;
        repeat (20) @(posedge clk);
        bus(1'b1, 4'h8, 32'h3, rd);
        bus(1'b0, 4'h8, 32'h0, rd);
        chk(rd, 32'h0);
        bus(1'b1, 4'hc, 32'h3, rd);
        repeat (3) @(posedge clk);
        chk(irq, 0);
        encRun <= 1'b1;
        repeat (40) @(posedge clk);
        bus(1'b0, 4'h8, 32'h0, rd);
        chk(rd, 32'h3);
        chk(irq, 1);
        bus(1'b0, 4'h4, 32'h0, rd);
        chk(rd & 32'h007f_8000, 32'h0032_0000);
        doReset();
        summarize();
    end
endmodule
bind aopc_port aopc_port_monitor mon (.clk, .sys_rst, .power_down_in, .outputEnable_n, .dither_enable,
    .gain_select, .formatSel, .ditherOn, .gainHigh, .analogPowerDown, .stabilizerOn, .sample_bits,
    .sampleBitsOe, .rangeFlagOe, .data_valid_clk_pos, .data_valid_clk_neg, .dataValidOe);
`default_nettype wire
